// file: hw/tapev_defines.svh
// Register offsets, field positions, reset values and limits of the
// tap event block. Included by the package users; no logic here.
`ifndef TAPEV_DEFINES_SVH
`define TAPEV_DEFINES_SVH

// Register offsets on the serial register port
`define TAPEV_ADDR_CONFIG 8'h21
`define TAPEV_ADDR_SOURCE 8'h22
`define TAPEV_ADDR_THS_X 8'h23
`define TAPEV_ADDR_THS_Y 8'h24
`define TAPEV_ADDR_THS_Z 8'h25

// Reset values
`define TAPEV_CFG_RESET 8'h00
`define TAPEV_SRC_RESET 8'h00
`define TAPEV_THS_RESET 7'h00
`define TAPEV_RD_IDLE 8'h00

// Field positions
`define TAPEV_CFG_ABORT_BIT 7
`define TAPEV_CFG_LATCH_BIT 6
`define TAPEV_SRC_ACTIVE_BIT 7
`define TAPEV_SRC_DBL_BIT 3
`define TAPEV_THS_MSB 6

// Largest threshold code while low-noise is set: 4 g at 0.063 g per count
`define TAPEV_LN_MAX_THS 7'h3F

// Sample counter steps
`define TAPEV_CNT_ZERO 8'h00
`define TAPEV_CNT_ONE 8'h01
`define TAPEV_CNT_MAX 8'hFF

`endif

// file: hw/tapev_pkg.sv
// Types shared by the tap event block and its per-axis detector.
// Assumes tapev_defines.svh supplies the numeric constants.
package tapev_pkg;

  typedef struct packed {
    logic doubleTapAbort;
    logic tapLatchEnable;
    logic zDoubleTapEnable;
    logic zSingleTapEnable;
    logic yDoubleTapEnable;
    logic ySingleTapEnable;
    logic xDoubleTapEnable;
    logic xSingleTapEnable;
  } tapev_cfg_t;

  typedef struct packed {
    logic tapEventActive;
    logic zTapSeen;
    logic yTapSeen;
    logic xTapSeen;
    logic doubleTapFirst;
    logic zTapSign;
    logic yTapSign;
    logic xTapSign;
  } tapev_src_t;

  typedef struct packed {
    logic [7:0] timeLimit;
    logic [7:0] latency;
    logic [7:0] window;
  } tapev_timing_t;

  typedef struct packed {
    logic singleHit;
    logic doubleHit;
    logic sign;
  } tapev_hit_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRST,
    ST_LATENCY,
    ST_WINDOW,
    ST_SECOND
  } tapev_state_t;

endpackage

// file: hw/tapev_axis_det.sv
// Single/double tap detector for one axis, stepped once per sample.
// Assumes samples arrive on clk_sys as a one-cycle valid strobe.
`timescale 1ns/1ps
`include "tapev_defines.svh"

module tapev_axis_det (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Sample and settings
  input wire logic sampleValid,
  input wire logic [7:0] accel,
  input wire logic [6:0] level,
  input wire tapev_pkg::tapev_timing_t timing,
  input wire logic doubleTapAbort,
  input wire logic singleEnable,
  input wire logic doubleEnable,
  // Detection result: one-cycle hit pulses, sign held from the last tap
  output tapev_pkg::tapev_hit_t hit
);

  tapev_pkg::tapev_state_t state;
  logic [7:0] cnt;
  logic [7:0] magnitude;
  logic [7:0] cntInc;
  logic above;
  logic pulseSign;
  logic latPulse;
  logic latAbort;
  logic latDone;
  logic firstValid;
  logic secondValid;
  logic enabled;

  assign magnitude = accel[7] ? 8'(~accel + `TAPEV_CNT_ONE) : accel;
  assign above = magnitude > {1'b0, level};
  assign cntInc = (cnt == `TAPEV_CNT_MAX) ? cnt : cnt + `TAPEV_CNT_ONE;
  assign latDone = cnt >= timing.latency;
  assign enabled = singleEnable | doubleEnable;
  assign firstValid = sampleValid && state == tapev_pkg::ST_FIRST &&
                      !above && cnt <= timing.timeLimit;
  assign secondValid = sampleValid && state == tapev_pkg::ST_SECOND &&
                       !above && cnt <= timing.timeLimit;

  // Sequence of one tap, latency and optional second tap
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= tapev_pkg::ST_IDLE;
      cnt <= `TAPEV_CNT_ZERO;
      pulseSign <= 1'b0;
      latPulse <= 1'b0;
      latAbort <= 1'b0;
    end else if (!enabled) begin
      state <= tapev_pkg::ST_IDLE;
      cnt <= `TAPEV_CNT_ZERO;
    end else if (sampleValid) begin
      case (state)
        tapev_pkg::ST_IDLE: begin
          if (above) begin
            state <= tapev_pkg::ST_FIRST;
            cnt <= `TAPEV_CNT_ONE;
            pulseSign <= accel[7];
          end
        end
        tapev_pkg::ST_FIRST: begin
          if (!above) begin
            state <= firstValid ? tapev_pkg::ST_LATENCY
                                : tapev_pkg::ST_IDLE;
            cnt <= `TAPEV_CNT_ZERO;
            latPulse <= 1'b0;
            latAbort <= 1'b0;
          end else if (cnt >= timing.timeLimit) begin
            state <= tapev_pkg::ST_IDLE;
          end else begin
            cnt <= cntInc;
          end
        end
        tapev_pkg::ST_LATENCY: begin
          if (latDone) begin
            cnt <= `TAPEV_CNT_ZERO;
            if (doubleEnable && !(latAbort && doubleTapAbort)) begin
              state <= tapev_pkg::ST_WINDOW;
            end else begin
              state <= tapev_pkg::ST_IDLE;
            end
          end else begin
            cnt <= cntInc;
            if (above) begin
              latPulse <= 1'b1;
            end else if (latPulse && doubleTapAbort) begin
              latAbort <= 1'b1;
            end
          end
        end
        tapev_pkg::ST_WINDOW: begin
          if (above) begin
            state <= tapev_pkg::ST_SECOND;
            cnt <= `TAPEV_CNT_ONE;
            pulseSign <= accel[7];
          end else if (cnt >= timing.window) begin
            state <= tapev_pkg::ST_IDLE;
          end else begin
            cnt <= cntInc;
          end
        end
        tapev_pkg::ST_SECOND: begin
          if (!above || cnt >= timing.timeLimit) begin
            state <= tapev_pkg::ST_IDLE;
            cnt <= `TAPEV_CNT_ZERO;
          end else begin
            cnt <= cntInc;
          end
        end
        default: begin
          state <= tapev_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Result pulses, gated by the event type enables
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hit <= '0;
    end else begin
      hit.singleHit <= firstValid && singleEnable;
      hit.doubleHit <= secondValid && doubleEnable;
      hit.sign <= pulseSign;
    end
  end

  sequence S_LAT_END_ABORTED;
    state == tapev_pkg::ST_LATENCY && sampleValid && enabled &&
      latDone && latAbort && doubleTapAbort;
  endsequence

  sequence S_FIRST_END_OK;
    state == tapev_pkg::ST_FIRST && sampleValid && enabled && !above &&
      cnt <= timing.timeLimit && singleEnable;
  endsequence

  AST_ABORT_TO_IDLE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    S_LAT_END_ABORTED |=> state == tapev_pkg::ST_IDLE)
    else $error("aborted latency did not return to idle");

  AST_NO_ABORT_WINDOW: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state == tapev_pkg::ST_LATENCY && sampleValid && latDone &&
      doubleEnable && !doubleTapAbort |=> state == tapev_pkg::ST_WINDOW)
    else $error("double tap not continued without abort");

  AST_FIRST_TAP_HIT: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    S_FIRST_END_OK |=> hit.singleHit &&
      state == tapev_pkg::ST_LATENCY)
    else $error("valid first tap not reported");

endmodule

// file: hw/tapev_top.sv
// Tap event configuration, source and threshold registers with three
// per-axis detectors. Assumes samples and the register port are
// driven from logic on clk_sys; timing values come from other blocks.
`timescale 1ns/1ps
`include "tapev_defines.svh"

// Overview of operation
// - Abort off: double tap continues despite latency taps
// - Abort on: latency tap start and end suspends
// - Latch enable selects latched source flags, reset 0
// - Six axis single/double enables, bits 5..0
// - Event reported only if axis and type enabled
// - Event active flag set on any event
// - Per-axis seen bits Z, Y, X at 6..4
// - Bit 3 marks double tap as trigger
// - Bits 2..0 give Z, Y, X sign
// - Latched event active freezes status until read
// - Source read clears all bits and interrupt
// - Three 7-bit thresholds, bit 7 reads zero
// - Threshold counts 0.063 g on fixed 8 g
// - Low-noise caps reachable threshold at 4 g
// - Tap starts when magnitude exceeds threshold
// - Thresholds reset to zero
// - Tap must fall below within time limit
// - Taps ignored during latency after first tap while abort is off
// - Second tap starts within window after latency
module tapev_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Acceleration samples, index 0 = X, 1 = Y, 2 = Z
  input wire logic sampleValid,
  input wire logic [2:0][7:0] accelSample,
  // Timing and system settings held elsewhere
  input wire tapev_pkg::tapev_timing_t tapTiming,
  input wire logic lowNoise,
  // Tap interrupt
  output logic tapIrq
);

  tapev_pkg::tapev_cfg_t cfgReg;
  tapev_pkg::tapev_src_t srcReg;
  tapev_pkg::tapev_src_t next_src;
  tapev_pkg::tapev_src_t newSrc;
  tapev_pkg::tapev_hit_t hits [3];
  logic [7:0] cfgBits;
  logic [2:0][6:0] thsReg;
  logic [2:0] axisSeen;
  logic [2:0] axisSign;
  logic [2:0] axisDouble;
  logic anyHit;
  logic frozen;
  logic srcRead;
  logic cfgWrite;
  logic [7:0] next_rd;

  assign cfgBits = cfgReg;
  assign srcRead = regRead && regAddr == `TAPEV_ADDR_SOURCE;
  assign cfgWrite = regWrite && regAddr == `TAPEV_ADDR_CONFIG;

  // Configuration register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfgReg <= `TAPEV_CFG_RESET;
    end else if (cfgWrite) begin
      cfgReg <= regWrData;
    end
  end

  // Per-axis threshold register, level clamp and detector
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_axis
      localparam logic [7:0] THS_ADDR = 8'(`TAPEV_ADDR_THS_X + i);
      logic [6:0] effLevel;

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          thsReg[i] <= `TAPEV_THS_RESET;
        end else if (regWrite && regAddr == THS_ADDR) begin
          thsReg[i] <= regWrData[`TAPEV_THS_MSB:0];
        end
      end

      // Codes are in 0.063 g steps on the fixed 8 g sample scale
      assign effLevel = (lowNoise && thsReg[i] > `TAPEV_LN_MAX_THS) ?
                        `TAPEV_LN_MAX_THS : thsReg[i];

      tapev_axis_det u_det (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .sampleValid(sampleValid),
        .accel(accelSample[i]),
        .level(effLevel),
        .timing(tapTiming),
        .doubleTapAbort(cfgReg.doubleTapAbort),
        .singleEnable(cfgBits[2*i]),
        .doubleEnable(cfgBits[2*i+1]),
        .hit(hits[i])
      );

      assign axisSeen[i] = hits[i].singleHit | hits[i].doubleHit;
      assign axisDouble[i] = hits[i].doubleHit;
      assign axisSign[i] = axisSeen[i] & hits[i].sign;
    end
  endgenerate

  assign anyHit = |axisSeen;
  assign frozen = cfgReg.tapLatchEnable && srcReg.tapEventActive;

  // Status word for the events of this cycle
  always_comb begin
    newSrc = '0;
    newSrc.tapEventActive = anyHit;
    newSrc.zTapSeen = axisSeen[2];
    newSrc.yTapSeen = axisSeen[1];
    newSrc.xTapSeen = axisSeen[0];
    newSrc.doubleTapFirst = |axisDouble;
    newSrc.zTapSign = axisSign[2];
    newSrc.yTapSign = axisSign[1];
    newSrc.xTapSign = axisSign[0];
  end

  // New events win over a read in the same cycle
  always_comb begin
    next_src = srcReg;
    if (anyHit && (!frozen || srcRead)) begin
      next_src = newSrc;
    end else if (srcRead) begin
      next_src = `TAPEV_SRC_RESET;
    end
  end

  // Source register and the interrupt that follows it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      srcReg <= `TAPEV_SRC_RESET;
      tapIrq <= 1'b0;
    end else begin
      srcReg <= next_src;
      tapIrq <= next_src.tapEventActive;
    end
  end

  // Read data mux, unmapped offsets read zero
  always_comb begin
    case (regAddr)
      `TAPEV_ADDR_CONFIG: next_rd = cfgReg;
      `TAPEV_ADDR_SOURCE: next_rd = srcReg;
      `TAPEV_ADDR_THS_X: next_rd = {1'b0, thsReg[0]};
      `TAPEV_ADDR_THS_Y: next_rd = {1'b0, thsReg[1]};
      `TAPEV_ADDR_THS_Z: next_rd = {1'b0, thsReg[2]};
      default: next_rd = `TAPEV_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdData <= `TAPEV_RD_IDLE;
    end else if (regRead) begin
      regRdData <= next_rd;
    end
  end

  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence S_SRC_READ_QUIET;
    srcRead && !anyHit;
  endsequence

  sequence S_LATCHED_HOLD;
    frozen && !srcRead;
  endsequence

  AST_READ_CLEARS_SOURCE: assert property (
    S_SRC_READ_QUIET |=> srcReg == `TAPEV_SRC_RESET && !tapIrq)
    else $error("source read did not clear status and interrupt");

  AST_READ_RETURNS_OLD: assert property (
    srcRead |=> regRdData == $past(srcReg))
    else $error("source read did not return value before clear");

  AST_IRQ_TRACKS_ACTIVE: assert property (
    tapIrq == srcReg.tapEventActive)
    else $error("interrupt differs from event active flag");

  AST_EVENT_SETS_ACTIVE: assert property (
    anyHit |=> srcReg.tapEventActive && tapIrq)
    else $error("event did not set event active flag");

  AST_FREEZE_WHEN_LATCHED: assert property (
    S_LATCHED_HOLD |=> $stable(srcReg))
    else $error("latched status changed before read");

  AST_UNLATCHED_UPDATES: assert property (
    anyHit && !cfgReg.tapLatchEnable |=> srcReg == $past(newSrc))
    else $error("unlatched status did not take latest event");

  AST_CFG_WRITE_TAKES: assert property (
    cfgWrite |=> cfgBits == $past(regWrData))
    else $error("configuration write not stored");

  AST_THS_TOP_BIT_ZERO: assert property (
    regRead && regAddr >= `TAPEV_ADDR_THS_X &&
      regAddr <= `TAPEV_ADDR_THS_Z |=> !regRdData[7])
    else $error("threshold bit 7 read as one");

  AST_X_SEEN_NEEDS_ENABLE: assert property (
    $rose(srcReg.xTapSeen) |-> $past(cfgBits[0] | cfgBits[1], 2))
    else $error("X event reported while X disabled");

  AST_LOW_NOISE_CAP: assert property (
    lowNoise |-> g_axis[0].effLevel <= `TAPEV_LN_MAX_THS)
    else $error("low-noise threshold exceeds 4 g code");

  AST_DOUBLE_MARK: assert property (
    anyHit && !frozen ##1 srcReg.doubleTapFirst |->
      $past(|axisDouble))
    else $error("double tap mark set without double event");

  sequence S_SRC_WRITE_ONLY;
    regWrite && regAddr == `TAPEV_ADDR_SOURCE && !srcRead && !anyHit;
  endsequence

  AST_RDDATA_HOLDS: assert property (
    !regRead |=> $stable(regRdData))
    else $error("read data changed without a read");

  AST_SRC_WRITE_IGNORED: assert property (
    S_SRC_WRITE_ONLY |=> $stable(srcReg))
    else $error("write to source register changed status");

  AST_READ_UNFREEZES: assert property (
    S_SRC_READ_QUIET |=> !frozen)
    else $error("status still frozen after source read");

  AST_CFG_HOLDS: assert property (
    !cfgWrite |=> $stable(cfgReg))
    else $error("configuration changed without a write");

  AST_THS_X_TAKES: assert property (
    regWrite && regAddr == `TAPEV_ADDR_THS_X |=>
      thsReg[0] == $past(regWrData[`TAPEV_THS_MSB:0]))
    else $error("X threshold write not stored");

  AST_THS_Y_TAKES: assert property (
    regWrite && regAddr == `TAPEV_ADDR_THS_Y |=>
      thsReg[1] == $past(regWrData[`TAPEV_THS_MSB:0]))
    else $error("Y threshold write not stored");

  AST_THS_Z_TAKES: assert property (
    regWrite && regAddr == `TAPEV_ADDR_THS_Z |=>
      thsReg[2] == $past(regWrData[`TAPEV_THS_MSB:0]))
    else $error("Z threshold write not stored");

  AST_UNMAPPED_READS_ZERO: assert property (
    regRead && regAddr > `TAPEV_ADDR_THS_Z |=> regRdData == `TAPEV_RD_IDLE)
    else $error("unmapped offset read as nonzero");

  AST_SIGN_NEEDS_SEEN: assert property (
    !(srcReg.xTapSign && !srcReg.xTapSeen) &&
      !(srcReg.yTapSign && !srcReg.yTapSeen) &&
      !(srcReg.zTapSign && !srcReg.zTapSeen))
    else $error("sign bit set for an axis without event");

  AST_ACTIVE_MEANS_AXIS: assert property (
    srcReg.tapEventActive ==
      (srcReg.xTapSeen || srcReg.yTapSeen || srcReg.zTapSeen))
    else $error("event active flag disagrees with axis bits");

  AST_Y_SEEN_NEEDS_ENABLE: assert property (
    $rose(srcReg.yTapSeen) |-> $past(cfgBits[2] | cfgBits[3], 2))
    else $error("Y event reported while Y disabled");

  AST_Z_SEEN_NEEDS_ENABLE: assert property (
    $rose(srcReg.zTapSeen) |-> $past(cfgBits[4] | cfgBits[5], 2))
    else $error("Z event reported while Z disabled");

  AST_DOUBLE_NEEDS_ENABLE: assert property (
    $rose(srcReg.doubleTapFirst) |->
      $past(cfgBits[1] | cfgBits[3] | cfgBits[5], 2))
    else $error("double tap reported while no double enable");

  AST_LEVEL_UNCAPPED: assert property (
    !lowNoise |-> g_axis[0].effLevel == thsReg[0])
    else $error("threshold altered while low-noise is off");

  AST_LOW_NOISE_CAP_Y: assert property (
    lowNoise |-> g_axis[1].effLevel <= `TAPEV_LN_MAX_THS)
    else $error("low-noise Y threshold exceeds 4 g code");

  AST_LOW_NOISE_CAP_Z: assert property (
    lowNoise |-> g_axis[2].effLevel <= `TAPEV_LN_MAX_THS)
    else $error("low-noise Z threshold exceeds 4 g code");

endmodule

// file: sim/tapev_host_model.sv
// Host side of the register port, driving reads and writes.
// Assumes one request per call, launched just after a clk_sys edge.
`timescale 1ns/1ps
module tapev_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
    regWrData = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clk_sys);
    regWrite <= 1'h0;
    // Released lines show no stale value
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk_sys);
    regRead <= 1'h0;
    regAddr <= ~a;
    @(negedge clk_sys);
    d = regRdData;
  endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the tap event block.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] regAddr;
  logic regWrite;
  logic regRead;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic sampleValid = 1'h0;
  logic [2:0][7:0] accelSample = '0;
  tapev_pkg::tapev_timing_t tapTiming = 24'h05_0108;
  logic lowNoise = 1'h0;
  logic tapIrq;
  int num_errors = 0;
  int checked = 0;

  tapev_top i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
    .regRdData(regRdData), .sampleValid(sampleValid),
    .accelSample(accelSample), .tapTiming(tapTiming),
    .lowNoise(lowNoise), .tapIrq(tapIrq)
  );

  tapev_host_model i_host (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData)
  );

  always #50 clk_sys = ~clk_sys;

  task automatic final_report();
    $display("Counts: checked=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(d, exp);
  endtask

  task automatic samp(input logic [7:0] x, y, z);
    @(posedge clk_sys);
    sampleValid <= 1'h1;
    accelSample <= {z, y, x};
    @(posedge clk_sys);
    sampleValid <= 1'h0;
  endtask

  // Above threshold for one sample, then quiet samples to settle
  task automatic tap(input logic [7:0] x, y, z);
    samp(x, y, z);
    repeat (5) samp(8'h00, 8'h00, 8'h00);
  endtask

  task automatic waitIrq();
    int n;
    for (n = 0; n < 30 && tapIrq !== 1'h1; n++) begin
      @(negedge clk_sys);
    end
    if (tapIrq !== 1'h1) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, tapIrq, 1'h1);
      final_report();
    end
  endtask

  task automatic setup(input logic [7:0] cfg, input logic [7:0] ths);
    // Disabling every axis first sends all detectors back to idle
    i_host.wr(8'h21, 8'h00);
    i_host.wr(8'h23, ths);
    i_host.wr(8'h24, ths);
    i_host.wr(8'h25, ths);
    i_host.wr(8'h21, cfg);
  endtask

  task automatic t_reset();
    rdChk(8'h21, 8'h00);
    rdChk(8'h22, 8'h00);
    rdChk(8'h23, 8'h00);
    rdChk(8'h24, 8'h00);
    rdChk(8'h25, 8'h00);
    rdChk(8'h30, 8'h00);
    i_host.wr(8'h23, 8'hFF);
    rdChk(8'h23, 8'h7F);
    i_host.wr(8'h21, 8'hFF);
    rdChk(8'h21, 8'hFF);
    i_host.wr(8'h22, 8'hFF);
    rdChk(8'h22, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_single();
    setup(8'h41, 8'h0A);
    samp(8'h14, 8'h00, 8'h00);
    samp(8'h00, 8'h00, 8'h00);
    waitIrq();
    rdChk(8'h22, 8'h90);
    chk({7'h00, tapIrq}, 8'h00);
    $display("test single done");
  endtask

  task automatic t_freeze();
    setup(8'h45, 8'h0A);
    tap(8'h14, 8'h00, 8'h00);
    tap(8'h00, 8'hEC, 8'h00);
    chk({7'h00, tapIrq}, 8'h01);
    rdChk(8'h22, 8'h90);
    rdChk(8'h22, 8'h00);
    $display("test freeze done");
  endtask

  task automatic t_sign();
    setup(8'h15, 8'h0A);
    tap(8'h00, 8'hEC, 8'h00);
    rdChk(8'h22, 8'hA2);
    tap(8'h00, 8'h00, 8'hEC);
    rdChk(8'h22, 8'hC4);
    tap(8'h00, 8'hEC, 8'h00);
    tap(8'h14, 8'h00, 8'h00);
    rdChk(8'h22, 8'h90);
    $display("test sign done");
  endtask

  task automatic t_disabled();
    setup(8'h42, 8'h0A);
    tap(8'h14, 8'h00, 8'h00);
    tap(8'h00, 8'h14, 8'h14);
    rdChk(8'h22, 8'h00);
    $display("test disabled done");
  endtask

  task automatic t_double();
    setup(8'h60, 8'h0A);
    samp(8'h00, 8'h00, 8'h14);
    samp(8'h00, 8'h00, 8'h00);
    samp(8'h00, 8'h00, 8'h00);
    samp(8'h00, 8'h00, 8'h00);
    tap(8'h00, 8'h00, 8'h14);
    rdChk(8'h22, 8'hC8);
    rdChk(8'h22, 8'h00);
    $display("test double done");
  endtask

  task automatic t_limit();
    setup(8'h41, 8'h0A);
    repeat (6) samp(8'h14, 8'h00, 8'h00);
    tap(8'h00, 8'h00, 8'h00);
    rdChk(8'h22, 8'h00);
    repeat (5) samp(8'h14, 8'h00, 8'h00);
    tap(8'h00, 8'h00, 8'h00);
    rdChk(8'h22, 8'h90);
    @(posedge clk_sys);
    accelSample <= {8'h14, 8'h14, 8'h14};
    repeat (3) @(posedge clk_sys);
    tap(8'h00, 8'h00, 8'h00);
    rdChk(8'h22, 8'h00);
    $display("test limit done");
  endtask

  // First Z tap, a tap inside latency, then a tap in the window
  task automatic dblSeq();
    samp(8'h00, 8'h00, 8'h14);
    samp(8'h00, 8'h00, 8'h00);
    samp(8'h00, 8'h00, 8'h14);
    repeat (4) samp(8'h00, 8'h00, 8'h00);
    tap(8'h00, 8'h00, 8'h14);
  endtask

  task automatic t_abort();
    @(posedge clk_sys);
    tapTiming <= 24'h05_0408;
    setup(8'h60, 8'h0A);
    dblSeq();
    rdChk(8'h22, 8'hC8);
    setup(8'hE0, 8'h0A);
    dblSeq();
    rdChk(8'h22, 8'h00);
    $display("test abort done");
  endtask

  task automatic t_window();
    setup(8'h60, 8'h0A);
    samp(8'h00, 8'h00, 8'h14);
    repeat (16) samp(8'h00, 8'h00, 8'h00);
    tap(8'h00, 8'h00, 8'h14);
    rdChk(8'h22, 8'h00);
    $display("test window done");
  endtask

  task automatic t_lownoise();
    setup(8'h41, 8'h7F);
    tap(8'h50, 8'h00, 8'h00);
    rdChk(8'h22, 8'h00);
    @(posedge clk_sys);
    lowNoise <= 1'h1;
    tap(8'h50, 8'h00, 8'h00);
    rdChk(8'h22, 8'h90);
    $display("test lownoise done");
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    t_reset();
    t_single();
    t_freeze();
    t_sign();
    t_disabled();
    t_double();
    t_limit();
    t_abort();
    t_window();
    t_lownoise();
    final_report();
  end
endmodule
